// file: pic_params.svh
// Offsets, field positions, codes and limits of the program interrupt control
`ifndef PIC_PARAMS_SVH
`define PIC_PARAMS_SVH

// Mask bit positions
`define PIC_MB_EXT_BASE     0
`define PIC_MB_CHAN_BASE    4
`define PIC_MB_CLOCK        8
`define PIC_MB_EXPBCD       9
`define PIC_MB_ARITH        10
`define PIC_MB_SEARCH       11
`define PIC_MASK_RESET      12'h0000

// Pending vector layout
`define PIC_IDX_ARITH       0
`define PIC_IDX_DIVIDE      1
`define PIC_IDX_EXPONENT    2
`define PIC_IDX_DECIMAL     3
`define PIC_IDX_EXT_BASE    4
`define PIC_IDX_CHAN_BASE   36
`define PIC_IDX_SEARCH      40
`define PIC_IDX_CLOCK       41
`define PIC_IDX_MANUAL      42
`define PIC_IDX_ASSOC       43
`define PIC_SOURCES         44

// Condition codes stored in the low half of the code word
`define PIC_CODE_CHAN_BASE  12'h0040
`define PIC_CODE_CLOCK      12'h0048
`define PIC_CODE_ARITH      12'h0049
`define PIC_CODE_SEARCH     12'h004D
`define PIC_CODE_MANUAL     12'h004E
`define PIC_CODE_ASSOC      12'h004F

// Fixed save and entry addresses
`define PIC_SAVE_ADDR       15'h0004
`define PIC_ENTRY_ADDR      15'h0005

// Exponent limit, two to the tenth minus one
`define PIC_EXP_LIMIT       12'h03FF

`endif

// file: pic_pkg.sv
// Types shared by the program interrupt control modules
package pic_pkg;
    typedef logic [11:0] pic_code_t;
    typedef enum logic [1:0] {
        PIC_OFF,
        PIC_ARMED,
        PIC_ON
    } pic_enable_e;
endpackage

// file: pic_priority_scan.sv
// Fixed priority scan of gated interrupt sources into a condition code
`include "pic_params.svh"
module pic_priority_scan
    import pic_pkg::*;
(
    input  wire logic [`PIC_SOURCES-1:0] active,
    output logic                         anyActive,
    output pic_code_t                    code
);
    pic_code_t codeTable [`PIC_SOURCES];

    // Code of every source, one entry per position
    genvar g;
    generate
        for (g = 0; g < `PIC_SOURCES; g++) begin : gCode
            if (g < `PIC_IDX_EXT_BASE) begin : gFault
                assign codeTable[g] = `PIC_CODE_ARITH + 12'(g);
            end else if (g < `PIC_IDX_CHAN_BASE) begin : gExt
                // Octal line digit above channel digit
                assign codeTable[g] = 12'(((g - 4) % 8) * 8 + (g - 4) / 8);
            end else if (g < `PIC_IDX_SEARCH) begin : gChan
                assign codeTable[g] = `PIC_CODE_CHAN_BASE + 12'(g - `PIC_IDX_CHAN_BASE);
            end else if (g == `PIC_IDX_SEARCH) begin : gSearch
                assign codeTable[g] = `PIC_CODE_SEARCH;
            end else if (g == `PIC_IDX_CLOCK) begin : gClock
                assign codeTable[g] = `PIC_CODE_CLOCK;
            end else if (g == `PIC_IDX_MANUAL) begin : gManual
                assign codeTable[g] = `PIC_CODE_MANUAL;
            end else begin : gAssoc
                assign codeTable[g] = `PIC_CODE_ASSOC;
            end
        end
    endgenerate

    // Scan from the top down so the lowest position is written last and wins
    always_comb begin
        anyActive = 1'b0;
        code      = 12'h0000;
        for (int i = `PIC_SOURCES - 1; i >= 0; i--) begin
            if (active[i]) begin
                anyActive = 1'b1;
                code      = codeTable[i];
            end
        end
    end
endmodule

// file: pic_program_interrupt_control.sv
// Program interrupt control: fault capture, mask, enable and recognition at fetch
`include "pic_params.svh"
module pic_program_interrupt_control
    import pic_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        addCheck,
    input  wire logic        addSignA,
    input  wire logic        addSignB,
    input  wire logic        addSignSum,
    input  wire logic        divCheck,
    input  wire logic [47:0] divDividendHigh,
    input  wire logic [47:0] divDivisor,
    input  wire logic        expCheck,
    input  wire logic [11:0] expResult,
    input  wire logic        decimalTrap,
    input  wire logic [3:0]  chanBlockEnd,
    input  wire logic [3:0]  chanDisconnect,
    input  wire logic        searchDone,
    input  wire logic        moveDone,
    input  wire logic [23:0] clockTime,
    input  wire logic [23:0] clockTarget,
    input  wire logic [31:0] extRequest,
    input  wire logic        manualPress,
    input  wire logic        assocRequest,
    input  wire logic        maskSet,
    input  wire logic        maskClear,
    input  wire logic        flagClear,
    input  wire logic        senseRequest,
    input  wire logic [11:0] operand,
    input  wire logic        enableRequest,
    input  wire logic        disableRequest,
    input  wire logic        fetchPoint,
    input  wire logic [14:0] programAddress,
    output logic [11:0]      interruptGateMask,
    output logic             interruptTaken,
    output logic [14:0]      savedAddress,
    output logic [14:0]      saveLocation,
    output pic_code_t        conditionCode,
    output logic [14:0]      entryAddress,
    output logic             senseHit,
    output logic             interruptsOn
);
    logic [3:0]               faultFlag;   // Arith, divide, exponent, decimal
    logic [3:0]               chanFlag;
    logic                     searchFlag;
    logic                     clockFlag;
    logic                     manualFlag;
    logic                     assocFlag;
    logic                     clockMatchLast;
    pic_enable_e              enableState;
    logic [`PIC_SOURCES-1:0]  pending;
    logic [`PIC_SOURCES-1:0]  gated;
    logic [11:0]              groupPending;
    logic                     anyActive;
    pic_code_t                scanCode;
    logic                     recognize;
    logic [3:0]               faultEvent;
    logic [3:0]               faultWipe;
    logic [3:0]               chanWipe;
    logic                     clockMatch;
    logic                     clockEvent;
    logic [11:0]              wipeSel;
    logic [11:0]              expMag;

    // Fault detection from the arithmetic core
    assign expMag = expResult[11] ? 12'(-expResult) : expResult;
    assign faultEvent[0] = addCheck & (addSignA == addSignB) & (addSignSum != addSignA);
    assign faultEvent[1] = divCheck & (divDivisor <= divDividendHigh);
    assign faultEvent[2] = expCheck & (expMag > `PIC_EXP_LIMIT);
    assign faultEvent[3] = decimalTrap;

    // Clock fires once per arrival at target, not for every cycle it sits there
    assign clockMatch = (clockTime == clockTarget);
    assign clockEvent = clockMatch & ~clockMatchLast;

    // Selective clear by instruction or by sensing; channel flags by instruction only
    assign wipeSel = (flagClear | senseRequest) ? operand : 12'h0000;
    assign faultWipe = {{2{wipeSel[`PIC_MB_EXPBCD]}}, {2{wipeSel[`PIC_MB_ARITH]}}};
    assign chanWipe  = flagClear ? operand[`PIC_MB_CHAN_BASE +: 4] : 4'h0;

    // Raw pending vector in scan order
    assign pending = {assocFlag, manualFlag, clockFlag, searchFlag, chanFlag,
                      extRequest, faultFlag};

    // Mask gating per channel
    genvar c;
    generate
        for (c = 0; c < 4; c++) begin : gChanGate
            assign gated[`PIC_IDX_EXT_BASE + 8*c +: 8] =
                pending[`PIC_IDX_EXT_BASE + 8*c +: 8] & {8{interruptGateMask[`PIC_MB_EXT_BASE + c]}};
            assign gated[`PIC_IDX_CHAN_BASE + c] =
                pending[`PIC_IDX_CHAN_BASE + c] & interruptGateMask[`PIC_MB_CHAN_BASE + c];
            assign groupPending[`PIC_MB_EXT_BASE + c]  = |extRequest[8*c +: 8];
            assign groupPending[`PIC_MB_CHAN_BASE + c] = chanFlag[c];
        end
    endgenerate

    // Remaining groups; manual and associated bypass the mask
    assign gated[1:0] = faultFlag[1:0] & {2{interruptGateMask[`PIC_MB_ARITH]}};
    assign gated[3:2] = faultFlag[3:2] & {2{interruptGateMask[`PIC_MB_EXPBCD]}};
    assign gated[`PIC_IDX_SEARCH] = searchFlag & interruptGateMask[`PIC_MB_SEARCH];
    assign gated[`PIC_IDX_CLOCK]  = clockFlag & interruptGateMask[`PIC_MB_CLOCK];
    assign gated[`PIC_IDX_MANUAL] = manualFlag;
    assign gated[`PIC_IDX_ASSOC]  = assocFlag;

    assign groupPending[`PIC_MB_CLOCK]  = clockFlag;
    assign groupPending[`PIC_MB_EXPBCD] = |faultFlag[3:2];
    assign groupPending[`PIC_MB_ARITH]  = |faultFlag[1:0];
    assign groupPending[`PIC_MB_SEARCH] = searchFlag;

    pic_priority_scan uScan (
        .active    (gated),
        .anyActive (anyActive),
        .code      (scanCode)
    );

    // Taken only at the fetch point so the current instruction is never started
    assign recognize = fetchPoint & (enableState == PIC_ON) & anyActive;

    // Internal fault flags; a new fault wins over a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            faultFlag <= 4'h0;
        end else begin
            faultFlag <= (faultFlag & ~faultWipe) | faultEvent;
        end
    end

    // Channel, search/move and clock flags
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            chanFlag       <= 4'h0;
            searchFlag     <= 1'b0;
            clockFlag      <= 1'b0;
            clockMatchLast <= 1'b0;
        end else begin
            chanFlag       <= (chanFlag & ~chanWipe) | chanBlockEnd | chanDisconnect;
            searchFlag     <= (searchFlag & ~wipeSel[`PIC_MB_SEARCH]) | searchDone | moveDone;
            clockFlag      <= (clockFlag & ~wipeSel[`PIC_MB_CLOCK]) | clockEvent;
            clockMatchLast <= clockMatch;
        end
    end

    // Unmasked sources cleared by their own recognition
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            manualFlag <= 1'b0;
            assocFlag  <= 1'b0;
        end else begin
            manualFlag <= (manualFlag & ~(recognize & scanCode == `PIC_CODE_MANUAL)) | manualPress;
            assocFlag  <= (assocFlag & ~(recognize & scanCode == `PIC_CODE_ASSOC)) | assocRequest;
        end
    end

    // Mask register; set wins if both select a bit
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            interruptGateMask <= `PIC_MASK_RESET;
        end else begin
            interruptGateMask <= (interruptGateMask & ~(maskClear ? operand : 12'h0000))
                               | (maskSet ? operand : 12'h0000);
        end
    end

    // Global enable; armed enable goes live after one more instruction
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            enableState <= PIC_OFF;
        end else if (recognize || disableRequest) begin
            enableState <= PIC_OFF;
        end else if (enableRequest) begin
            enableState <= PIC_ARMED;
        end else begin
            unique case (enableState)
                PIC_OFF:   enableState <= PIC_OFF;
                PIC_ARMED: enableState <= fetchPoint ? PIC_ON : PIC_ARMED;
                PIC_ON:    enableState <= PIC_ON;
            endcase
        end
    end

    // Recognition outputs toward the core
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            interruptTaken <= 1'b0;
            savedAddress   <= 15'h0000;
            conditionCode  <= 12'h0000;
        end else begin
            interruptTaken <= recognize;
            if (recognize) begin
                savedAddress  <= programAddress;
                conditionCode <= scanCode;
            end
        end
    end

    // Sense answer, independent of the mask
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            senseHit <= 1'b0;
        end else if (senseRequest) begin
            senseHit <= |(groupPending & operand);
        end
    end

    // Fixed addresses and enable status
    assign saveLocation = `PIC_SAVE_ADDR;
    assign entryAddress = `PIC_ENTRY_ADDR;
    assign interruptsOn = (enableState == PIC_ON);
endmodule

// file: pic_periph_model.sv
// Peripheral controllers driving the external request lines
module pic_periph_model (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic [31:0] raise,
    input  wire logic [31:0] withdraw,
    output logic      [31:0] extRequest
);
    timeunit 1ns;
    timeprecision 1ps;
    // A line stays up until the processor tells its controller to drop it
    always_ff @(posedge sys_clk) begin
        if (reset)
            extRequest <= 32'h0000_0000;
        else
            extRequest <= (extRequest | raise) & ~withdraw;
    end
endmodule

// file: pic_program_interrupt_control_chk.sv
// Port checks for the program interrupt control
module pic_program_interrupt_control_chk (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        fetchPoint,
    input wire logic [14:0] programAddress,
    input wire logic        maskSet,
    input wire logic        maskClear,
    input wire logic [11:0] operand,
    input wire logic        disableRequest,
    input wire logic [11:0] interruptGateMask,
    input wire logic        interruptTaken,
    input wire logic [14:0] savedAddress,
    input wire logic [14:0] saveLocation,
    input wire logic [14:0] entryAddress,
    input wire logic        interruptsOn
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // Recognition only at a fetch point while enabled
    property p_take; interruptTaken |-> $past(fetchPoint) && $past(interruptsOn); endproperty
    a_take: assert property (p_take) else $error("taken without enabled fetch");
    property p_off; interruptTaken |-> !interruptsOn; endproperty
    a_off: assert property (p_off) else $error("still enabled after entry");
    property p_pulse; interruptTaken |=> !interruptTaken; endproperty
    a_pulse: assert property (p_pulse) else $error("taken pulse too long");
    property p_saved; interruptTaken |-> savedAddress == $past(programAddress); endproperty
    a_saved: assert property (p_saved) else $error("wrong saved address");
    property p_fixed; saveLocation == 15'h0004 && entryAddress == 15'h0005; endproperty
    a_fixed: assert property (p_fixed) else $error("wrong fixed addresses");
    // Mask is a set/clear register; it moves only on those strobes
    property p_set; maskSet |=> interruptGateMask == ($past(interruptGateMask) | $past(operand)); endproperty
    a_set: assert property (p_set) else $error("mask set wrong");
    property p_clr; maskClear && !maskSet |=> interruptGateMask == ($past(interruptGateMask) & ~$past(operand));
    endproperty
    a_clr: assert property (p_clr) else $error("mask clear wrong");
    property p_hold; !maskSet && !maskClear |=> $stable(interruptGateMask); endproperty
    a_hold: assert property (p_hold) else $error("mask moved by itself");
    property p_dis; disableRequest |=> !interruptsOn; endproperty
    a_dis: assert property (p_dis) else $error("disable ignored");
    property p_arm; $rose(interruptsOn) |-> $past(fetchPoint); endproperty
    a_arm: assert property (p_arm) else $error("enable took effect early");
    c_take: cover property (interruptTaken);
    c_on: cover property ($rose(interruptsOn));
    // Bench strobes are one cycle apart at best, so a clear and the next set sit two edges apart
    c_clr: cover property (maskClear ##2 maskSet);
endmodule

bind pic_program_interrupt_control pic_program_interrupt_control_chk u_chk (
    .sys_clk, .reset, .fetchPoint, .programAddress, .maskSet, .maskClear, .operand, .disableRequest,
    .interruptGateMask, .interruptTaken, .savedAddress, .saveLocation, .entryAddress, .interruptsOn
);

// file: test_program_interrupt_control.sv
// Self-checking bench for the program interrupt control
module test_program_interrupt_control
    import pic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    logic [22:0] st = 23'h00_0000;
    logic        addSignA = 1'b0, addSignB = 1'b0, addSignSum = 1'b0;
    logic [47:0] divDividendHigh = 48'h0000_0000_0010, divDivisor = 48'h0000_0000_0011;
    logic [11:0] expResult = 12'h3FF, operand = 12'h000, m = 12'h000, interruptGateMask;
    logic [23:0] clockTime = 24'h00_0100, clockTarget = 24'h00_0101;
    logic [31:0] extRequest, raise = 32'h0000_0000, withdraw = 32'h0000_0000;
    logic [14:0] programAddress = 15'h0000, savedAddress, saveLocation, entryAddress;
    pic_code_t   conditionCode;
    logic        interruptTaken, senseHit, interruptsOn;
    int          errors = 0, comparisons = 0;

    initial forever #2.5 sys_clk = ~sys_clk;
    pic_periph_model u_periph (.sys_clk, .reset, .raise, .withdraw, .extRequest);
    // Strobes share one vector so a single task pulses any of them
    pic_program_interrupt_control u_dut (
        .sys_clk, .reset, .addCheck(st[0]), .addSignA, .addSignB, .addSignSum, .divCheck(st[1]),
        .divDividendHigh, .divDivisor, .expCheck(st[2]), .expResult, .decimalTrap(st[3]),
        .chanBlockEnd(st[18:15]), .chanDisconnect(st[22:19]), .searchDone(st[4]), .moveDone(st[5]),
        .clockTime, .clockTarget, .extRequest, .manualPress(st[6]), .assocRequest(st[7]),
        .maskSet(st[8]), .maskClear(st[9]), .flagClear(st[10]), .senseRequest(st[11]), .operand,
        .enableRequest(st[12]), .disableRequest(st[13]), .fetchPoint(st[14]), .programAddress,
        .interruptGateMask, .interruptTaken, .savedAddress, .saveLocation, .conditionCode,
        .entryAddress, .senseHit, .interruptsOn
    );

    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    // One-cycle strobe; the address moves each time so stale saves show
    task automatic step(input int b, input logic [11:0] v);
        @(posedge sys_clk);
        st <= 23'h00_0001 << b;
        operand <= v;
        programAddress <= 15'($urandom);
        @(posedge sys_clk);
        st <= 23'h00_0000;
    endtask
    task automatic mask(input int b, input logic [11:0] v);
        step(b, v);
        m = (b == 8) ? (m | v) : (m & ~v);
        #1 chk(interruptGateMask === m, "mask");
    endtask
    task automatic arm;
        step(12, 12'h000);
        #1 chk(interruptsOn === 1'b0, "enabled early");
        step(14, 12'h000);
        #1 chk(interruptsOn === 1'b1, "not enabled");
    endtask
    task automatic take(input pic_code_t c, input logic hit);
        step(14, 12'h000);
        #1 chk(interruptTaken === hit && (hit === 1'b0 || conditionCode === c
            && savedAddress === programAddress), "take");
        @(posedge sys_clk);
        #1 chk(interruptTaken === 1'b0, "pulse");
    endtask
    task automatic next(input pic_code_t c, input logic [11:0] clr);
        arm();
        take(c, 1'b1);
        step(10, clr);
    endtask
    // Code expected for a strobe position
    function automatic pic_code_t codeOf(input int b);
        if (b < 4)
            return 12'h049 + 12'(b);
        if (b < 6)
            return 12'h04D;
        if (b < 8)
            return 12'h04E + 12'(b - 6);
        return 12'h040 + 12'((b - 15) % 4);
    endfunction
    task automatic finish_test;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Cut a hang short; the sequence needs under 2000 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        $display("mismatch at %0t: timeout", $time);
        finish_test();
    end

    // Main sequence
    initial begin
        int n;
        int k;
        void'($urandom(56329));
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        #1 chk(interruptGateMask === 12'h000 && saveLocation === 15'h0004 && entryAddress === 15'h0005, "reset");
        for (int i = 0; i < 6; i++) begin
            mask(8, 12'($urandom));
            mask(9, 12'($urandom));
        end
        mask(8, 12'hFFF);
        // Boundary operands one step short of a fault
        for (int b = 0; b < 3; b++)
            step(b, 12'h000);
        arm();
        take(12'h000, 1'b0);
        step(13, 12'h000);
        #1 chk(interruptsOn === 1'b0, "disable");
        @(posedge sys_clk);
        addSignSum <= 1'b1;
        divDivisor <= 48'h0000_0000_0010;
        expResult <= 12'h400;
        for (int b = 0; b < 23; b++) begin
            if (b < 8 || b > 14) begin
                step(b, 12'h000);
                next(codeOf(b), 12'hFFF);
            end
        end
        // Negative operands and underflow mirror the positive cases
        addSignA <= 1'b1;
        addSignB <= 1'b1;
        addSignSum <= 1'b0;
        expResult <= 12'hBFF;
        step(0, 12'h000);
        next(12'h049, 12'h400);
        step(2, 12'h000);
        next(12'h04B, 12'h200);
        // Mixed signs never overflow; magnitude 1023 is still in range
        addSignB <= 1'b0;
        expResult <= 12'hC01;
        step(0, 12'h000);
        step(2, 12'h000);
        arm();
        take(12'h000, 1'b0);
        step(13, 12'h000);
        addSignB <= 1'b1;
        step(6, 12'h000);
        step(3, 12'h000);
        step(0, 12'h000);
        next(12'h049, 12'h400);
        next(12'h04C, 12'h200);
        next(12'h04E, 12'h000);
        mask(9, 12'h400);
        step(0, 12'h000);
        arm();
        take(12'h000, 1'b0);
        mask(8, 12'h400);
        take(12'h049, 1'b1);
        step(10, 12'h400);
        mask(9, 12'hFFF);
        step(6, 12'h000);
        take(12'h000, 1'b0);
        next(12'h04E, 12'h000);
        step(7, 12'h000);
        next(12'h04F, 12'h000);
        arm();
        take(12'h000, 1'b0);
        step(0, 12'h000);
        step(11, 12'h400);
        #1 chk(senseHit === 1'b1, "sense");
        mask(8, 12'h500);
        take(12'h000, 1'b0);
        step(13, 12'h000);
        clockTarget <= clockTime;
        next(12'h048, 12'h100);
        // Two controller lines; the lower index must win
        mask(8, 12'h00F);
        n = $urandom_range(30, 0);
        k = $urandom_range(31, n + 1);
        @(posedge sys_clk);
        raise <= (32'h0000_0001 << n) | (32'h0000_0001 << k);
        @(posedge sys_clk);
        raise <= 32'h0000_0000;
        next(12'((n % 8) * 8 + n / 8), 12'h000);
        withdraw <= 32'h0000_0001 << n;
        next(12'((k % 8) * 8 + k / 8), 12'h000);
        withdraw <= 32'hFFFF_FFFF;
        arm();
        take(12'h000, 1'b0);
        finish_test();
    end
endmodule
